// *** verilog/dual_timer_ctrl.sv ***
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_ctrl (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic event_in,
   output logic shared_timer_output
);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic hits_idx(input logic [31:0] addr,
                                     input logic [15:0] idx);
      hits_idx = (addr[31:2] == {14'h0000, idx});
   endfunction

   function automatic logic [3:0] nibble(input logic [7:0] b,
                                         input logic hi);
      nibble = hi ? b[7:4] : b[3:0];
   endfunction

   function automatic logic [7:0] set_nibble(input logic [7:0] b,
                                             input logic hi,
                                             input logic [3:0] n);
      set_nibble = hi ? {n, b[3:0]} : {b[7:4], n};
   endfunction

   // Normal output toggles on underflow; PWM drops on underflow and
   // rises on compare match
   function automatic logic next_out(input logic cur, input logic pwm,
                                     input logic uf, input logic hit);
      if (uf) begin
         next_out = pwm ? 1'b0 : ~cur;
      end else if (pwm && hit) begin
         next_out = 1'b1;
      end else begin
         next_out = cur;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [3:0] mode_q;
   logic [3:0] outcfg_q;
   logic run0_q;
   logic run1_q;
   logic [7:0] rld0_q;
   logic [7:0] rld1_q;
   logic [7:0] cmp0_q;
   logic [7:0] cmp1_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [3:0] rd_d;
   logic mapped_d;
   logic access;
   logic wr_en;
   logic rst0_strobe;
   logic rst1_strobe;
   logic [6:0] tick_cnt_q;
   logic tick_en;
   logic ev_level;
   logic ev_prev_q;
   logic ev_rise;
   logic ev_fall;
   logic ev_edge;
   logic t0_tick;
   logic t1_tick;
   logic [7:0] cnt0;
   logic [7:0] cnt1;
   logic uf0;
   logic uf1;
   logic hit0;
   logic hit1;
   logic eq0;
   logic eq1;
   logic hit1_eff;
   logic t0_out_q;
   logic t1_out_q;
   logic shared_q;
   logic wide;

   assign wide = mode_q[dual_timer_pkg::MODE_WIDE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // APB slave

   // Every access phase takes two cycles so read data leaves a flop
   assign access = psel & penable & ~pready_q;
   assign wr_en = psel & penable & pwrite & pready_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= access;
         pslverr_q <= access & ~mapped_d;
         if (access && !pwrite) begin
            prdata_q <= {28'h0000000, rd_d};
         end
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // Read mux; write-only reset bits read as zero
   always_comb begin
      rd_d = 4'h0;
      mapped_d = 1'b1;
      if (hits_idx(paddr, dual_timer_pkg::IDX_MODE)) begin
         rd_d = mode_q;
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_OUTCFG)) begin
         rd_d = outcfg_q;
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_RUNRST)) begin
         rd_d[dual_timer_pkg::RUN_RUN1_BIT] = run1_q;
         rd_d[dual_timer_pkg::RUN_RUN0_BIT] = run0_q;
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_RLD0_LO)) begin
         rd_d = nibble(rld0_q, 1'b0);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_RLD0_HI)) begin
         rd_d = nibble(rld0_q, 1'b1);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_RLD1_LO)) begin
         rd_d = nibble(rld1_q, 1'b0);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_RLD1_HI)) begin
         rd_d = nibble(rld1_q, 1'b1);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CNT0_LO)) begin
         rd_d = nibble(cnt0, 1'b0);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CNT0_HI)) begin
         rd_d = nibble(cnt0, 1'b1);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CNT1_LO)) begin
         rd_d = nibble(cnt1, 1'b0);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CNT1_HI)) begin
         rd_d = nibble(cnt1, 1'b1);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CMP0_LO)) begin
         rd_d = nibble(cmp0_q, 1'b0);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CMP0_HI)) begin
         rd_d = nibble(cmp0_q, 1'b1);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CMP1_LO)) begin
         rd_d = nibble(cmp1_q, 1'b0);
      end else if (hits_idx(paddr, dual_timer_pkg::IDX_CMP1_HI)) begin
         rd_d = nibble(cmp1_q, 1'b1);
      end else begin
         mapped_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= dual_timer_pkg::NIB_RESET;
      end else if (wr_en && hits_idx(paddr, dual_timer_pkg::IDX_MODE)) begin
         mode_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outcfg_q <= dual_timer_pkg::NIB_RESET;
      end else if (wr_en &&
                   hits_idx(paddr, dual_timer_pkg::IDX_OUTCFG)) begin
         outcfg_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run0_q <= 1'b0;
         run1_q <= 1'b0;
      end else if (wr_en &&
                   hits_idx(paddr, dual_timer_pkg::IDX_RUNRST)) begin
         run0_q <= pwdata[dual_timer_pkg::RUN_RUN0_BIT];
         run1_q <= pwdata[dual_timer_pkg::RUN_RUN1_BIT];
      end
   end

   assign rst0_strobe = wr_en &
      hits_idx(paddr, dual_timer_pkg::IDX_RUNRST) &
      pwdata[dual_timer_pkg::RUN_RST0_BIT];
   assign rst1_strobe = wr_en &
      hits_idx(paddr, dual_timer_pkg::IDX_RUNRST) &
      pwdata[dual_timer_pkg::RUN_RST1_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rld0_q <= dual_timer_pkg::BYTE_RESET;
         rld1_q <= dual_timer_pkg::BYTE_RESET;
      end else if (wr_en) begin
         if (hits_idx(paddr, dual_timer_pkg::IDX_RLD0_LO)) begin
            rld0_q <= set_nibble(rld0_q, 1'b0, pwdata[3:0]);
         end
         if (hits_idx(paddr, dual_timer_pkg::IDX_RLD0_HI)) begin
            rld0_q <= set_nibble(rld0_q, 1'b1, pwdata[3:0]);
         end
         if (hits_idx(paddr, dual_timer_pkg::IDX_RLD1_LO)) begin
            rld1_q <= set_nibble(rld1_q, 1'b0, pwdata[3:0]);
         end
         if (hits_idx(paddr, dual_timer_pkg::IDX_RLD1_HI)) begin
            rld1_q <= set_nibble(rld1_q, 1'b1, pwdata[3:0]);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp0_q <= dual_timer_pkg::BYTE_RESET;
         cmp1_q <= dual_timer_pkg::BYTE_RESET;
      end else if (wr_en) begin
         if (hits_idx(paddr, dual_timer_pkg::IDX_CMP0_LO)) begin
            cmp0_q <= set_nibble(cmp0_q, 1'b0, pwdata[3:0]);
         end
         if (hits_idx(paddr, dual_timer_pkg::IDX_CMP0_HI)) begin
            cmp0_q <= set_nibble(cmp0_q, 1'b1, pwdata[3:0]);
         end
         if (hits_idx(paddr, dual_timer_pkg::IDX_CMP1_LO)) begin
            cmp1_q <= set_nibble(cmp1_q, 1'b0, pwdata[3:0]);
         end
         if (hits_idx(paddr, dual_timer_pkg::IDX_CMP1_HI)) begin
            cmp1_q <= set_nibble(cmp1_q, 1'b1, pwdata[3:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Count clocks

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 7'h00;
      end else if (tick_en) begin
         tick_cnt_q <= 7'h00;
      end else begin
         tick_cnt_q <= tick_cnt_q + 7'h01;
      end
   end

   assign tick_en =
      (tick_cnt_q == 7'(dual_timer_pkg::TICK_CYCLES - 1));

   event_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .raw_in(event_in),
      .filter_on(mode_q[dual_timer_pkg::MODE_FILTER_BIT]),
      .level_out(ev_level)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_prev_q <= 1'b0;
      end else begin
         ev_prev_q <= ev_level;
      end
   end

   assign ev_rise = ev_level & ~ev_prev_q;
   assign ev_fall = ~ev_level & ev_prev_q;
   assign ev_edge = mode_q[dual_timer_pkg::MODE_POL_BIT] ? ev_rise : ev_fall;
   assign t0_tick = mode_q[dual_timer_pkg::MODE_EVENT_BIT] ? ev_edge : tick_en;
   assign t1_tick = wide ? uf0 : tick_en;

   ////////////////////////////////////////////////////////////////////////
   // Timers

   down_counter8 u_timer0 (
      .pclk(pclk),
      .presetn(presetn),
      .run(run0_q),
      .tick(t0_tick),
      .reload_strobe(rst0_strobe),
      .reload_val(rld0_q),
      .compare_val(cmp0_q),
      .count(cnt0),
      .underflow(uf0),
      .hit(hit0),
      .equal(eq0)
   );

   down_counter8 u_timer1 (
      .pclk(pclk),
      .presetn(presetn),
      .run(run1_q),
      .tick(t1_tick),
      .reload_strobe(rst1_strobe),
      .reload_val(rld1_q),
      .compare_val(cmp1_q),
      .count(cnt1),
      .underflow(uf1),
      .hit(hit1),
      .equal(eq1)
   );

   // 16-bit match needs both bytes equal
   assign hit1_eff = wide ? (hit0 & eq1) : hit1;

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t0_out_q <= 1'b0;
         t1_out_q <= 1'b0;
      end else begin
         t0_out_q <= next_out(t0_out_q,
            outcfg_q[dual_timer_pkg::OUT_PWM0_BIT], uf0, hit0);
         t1_out_q <= next_out(t1_out_q,
            outcfg_q[dual_timer_pkg::OUT_PWM1_BIT], uf1, hit1_eff);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_q <= 1'b0;
      end else if (!outcfg_q[dual_timer_pkg::OUT_ON_BIT]) begin
         shared_q <= 1'b0;
      end else begin
         shared_q <= outcfg_q[dual_timer_pkg::OUT_SRC_BIT] ?
            t1_out_q : t0_out_q;
      end
   end

   assign shared_timer_output = shared_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   chk_reload_t0: assert property (
      @(posedge pclk) disable iff (!presetn)
      rst0_strobe |=> cnt0 == $past(rld0_q))
      else $error("timer 0 not reloaded by reset strobe");

   chk_reload_t1: assert property (
      @(posedge pclk) disable iff (!presetn)
      rst1_strobe |=> cnt1 == $past(rld1_q))
      else $error("timer 1 not reloaded by reset strobe");

   chk_hold_t0: assert property (
      @(posedge pclk) disable iff (!presetn)
      !run0_q && !rst0_strobe |=> $stable(cnt0))
      else $error("timer 0 moved while stopped");

   chk_hold_t1: assert property (
      @(posedge pclk) disable iff (!presetn)
      !run1_q && !rst1_strobe |=> $stable(cnt1))
      else $error("timer 1 moved while stopped");

   chk_output_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      !outcfg_q[dual_timer_pkg::OUT_ON_BIT] |=> !shared_timer_output)
      else $error("shared output active while off");

   chk_output_route: assert property (
      @(posedge pclk) disable iff (!presetn)
      outcfg_q[dual_timer_pkg::OUT_ON_BIT] &&
      outcfg_q[dual_timer_pkg::OUT_SRC_BIT]
      |=> shared_timer_output == $past(t1_out_q))
      else $error("shared output not from timer 1");

   chk_chain_step: assert property (
      @(posedge pclk) disable iff (!presetn)
      wide && !uf0 && !rst1_strobe |=> $stable(cnt1))
      else $error("timer 1 stepped without timer 0 underflow");

   chk_event_step: assert property (
      @(posedge pclk) disable iff (!presetn)
      mode_q[dual_timer_pkg::MODE_EVENT_BIT] && !ev_edge && !rst0_strobe
      |=> $stable(cnt0))
      else $error("timer 0 stepped without an event edge");

   chk_underflow_reload: assert property (
      @(posedge pclk) disable iff (!presetn)
      uf0 |=> cnt0 == $past(rld0_q) && !t0_out_q ==
         $past(outcfg_q[dual_timer_pkg::OUT_PWM0_BIT] || t0_out_q))
      else $error("timer 0 underflow handled wrongly");

   chk_pwm_rise: assert property (
      @(posedge pclk) disable iff (!presetn)
      outcfg_q[dual_timer_pkg::OUT_PWM0_BIT] && hit0 && !uf0
      |=> t0_out_q)
      else $error("timer 0 PWM did not rise on match");

endmodule
`default_nettype wire

// *** verilog/dual_timer_pkg.sv ***
`default_nettype none
package dual_timer_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_MODE = 16'hff80;
   localparam logic [15:0] IDX_OUTCFG = 16'hff81;
   localparam logic [15:0] IDX_RUNRST = 16'hff82;
   localparam logic [15:0] IDX_RLD0_LO = 16'hff84;
   localparam logic [15:0] IDX_RLD0_HI = 16'hff85;
   localparam logic [15:0] IDX_RLD1_LO = 16'hff86;
   localparam logic [15:0] IDX_RLD1_HI = 16'hff87;
   localparam logic [15:0] IDX_CNT0_LO = 16'hff88;
   localparam logic [15:0] IDX_CNT0_HI = 16'hff89;
   localparam logic [15:0] IDX_CNT1_LO = 16'hff8a;
   localparam logic [15:0] IDX_CNT1_HI = 16'hff8b;
   localparam logic [15:0] IDX_CMP0_LO = 16'hff8c;
   localparam logic [15:0] IDX_CMP0_HI = 16'hff8d;
   localparam logic [15:0] IDX_CMP1_LO = 16'hff8e;
   localparam logic [15:0] IDX_CMP1_HI = 16'hff8f;

   // timer_mode_config fields
   localparam int MODE_WIDE_BIT = 3;
   localparam int MODE_EVENT_BIT = 2;
   localparam int MODE_FILTER_BIT = 1;
   localparam int MODE_POL_BIT = 0;
   // timer_output_config fields
   localparam int OUT_PWM1_BIT = 3;
   localparam int OUT_PWM0_BIT = 2;
   localparam int OUT_SRC_BIT = 1;
   localparam int OUT_ON_BIT = 0;
   // timer_run_reset_ctrl fields
   localparam int RUN_RST1_BIT = 3;
   localparam int RUN_RUN1_BIT = 2;
   localparam int RUN_RST0_BIT = 1;
   localparam int RUN_RUN0_BIT = 0;

   // Reset values
   localparam logic [3:0] NIB_RESET = 4'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_NS = 1000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FILTER_NS = 200;
   localparam int FILTER_CYCLES =
      (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** verilog/event_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module event_filter (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Event input and selection
   input wire logic raw_in,
   input wire logic filter_on,
   // Cleaned level
   output logic level_out
);
   logic stable_q;
   logic [4:0] cnt_q;

   ////////////////////////////////////////////////////////////////////////
   // noise rejection window
   // A glitch shorter than the window never reaches the stable level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_q <= 1'b0;
         cnt_q <= 5'h00;
      end else if (raw_in == stable_q) begin
         cnt_q <= 5'h00;
      end else if (cnt_q == 5'(dual_timer_pkg::FILTER_CYCLES - 1)) begin
         stable_q <= raw_in;
         cnt_q <= 5'h00;
      end else begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   assign level_out = filter_on ? stable_q : raw_in;
endmodule
`default_nettype wire

// *** verilog/down_counter8.sv ***
`timescale 1ns/1ns
`default_nettype none
module down_counter8 (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic tick,
   input wire logic reload_strobe,
   input wire logic [7:0] reload_val,
   input wire logic [7:0] compare_val,
   // State
   output logic [7:0] count,
   output logic underflow,
   output logic hit,
   output logic equal
);
   logic step;

   assign step = run & tick & ~reload_strobe;

   ////////////////////////////////////////////////////////////////////////
   // count down, reload on underflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= dual_timer_pkg::BYTE_RESET;
      end else if (reload_strobe) begin
         count <= reload_val;
      end else if (step) begin
         count <= (count == 8'h00) ? reload_val : count - 8'h01;
      end
   end

   assign underflow = step & (count == 8'h00);
   assign equal = (count == compare_val);
   assign hit = step & equal;
endmodule
`default_nettype wire

// *** tb/event_source.sv ***
`timescale 1ns/1ns
`default_nettype none
module event_source (
   // Clock
   input wire logic pclk,
   // Event pin
   output logic event_in
);
   ////////////////////////////////////////////////////////////////////////
   // The pin idles low; no rule binds this side, so the model only makes
   // clean pulses of a chosen width, changed just after a rising edge
   initial event_in = 1'b0;

   task automatic send(input int n, input int w);
      repeat (n) begin
         @(posedge pclk);
         event_in <= 1'b1;
         repeat (w) @(posedge pclk);
         event_in <= 1'b0;
         repeat (w - 1) @(posedge pclk);
      end
      // Settling room covers the filter delay
      repeat (30) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// *** tb/dual_timer_ctrl_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module dual_timer_ctrl_tb_top;
   typedef struct {
      logic [7:0] idx;
      logic wr;
      logic [3:0] wd;
      logic [3:0] exp;
      logic err;
   } row_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic event_in;
   logic shared_timer_output;
   logic [31:0] rdat;
   logic rerr;
   int err_count = 0;
   int checks = 0;
   row_type rows [15];

   always #5 pclk = ~pclk;

   dual_timer_ctrl i_dual_timer_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_in(event_in),
      .shared_timer_output(shared_timer_output));
   event_source i_event_source (.pclk(pclk), .event_in(event_in));

   ////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("Counts: %0d checks, %0d mismatches", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk_data(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: data %h expected %h", $time, got, exp);
      end
   endtask

   task chk_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // Index to byte address is times four
   task apb(input logic [7:0] idx, input logic w, input logic [3:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0, 8'hff, idx, 2'b00};
      pwdata <= {28'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         err_count++;
         conclude();
      end
   endtask

   task wr(input logic [7:0] idx, input logic [3:0] d);
      apb(idx, 1'b1, d);
   endtask

   task rd_chk(input logic [7:0] idx, input logic [3:0] exp);
      apb(idx, 1'b0, 4'h0);
      chk_data(rdat, {28'h0, exp});
   endtask

   // Bounded polling; a live counter may need a tick or two
   task poll(input logic [7:0] idx, input logic [3:0] exp);
      int n;
      n = 0;
      do begin
         apb(idx, 1'b0, 4'h0);
         n++;
      end while (rdat !== {28'h0, exp} && n < 400);
      chk_data(rdat, {28'h0, exp});
   endtask

   task wait_out(input logic v);
      int n;
      n = 0;
      while (shared_timer_output !== v && n < 450) begin
         @(posedge pclk);
         n++;
      end
      chk_flag(shared_timer_output, v);
   endtask

   task stays(input logic v);
      logic bad;
      bad = 1'b0;
      repeat (450) begin
         @(posedge pclk);
         if (shared_timer_output !== v)
            bad = 1'b1;
      end
      chk_flag(bad, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{'h80,0,0,0,0}, '{'h81,0,0,0,0}, '{'h82,0,0,0,0},
         '{'h84,0,0,0,0}, '{'h8d,0,0,0,0}, '{'h80,1,'ha,'ha,0},
         '{'h81,1,5,5,0}, '{'h84,1,9,9,0}, '{'h85,1,'hc,'hc,0},
         '{'h86,1,3,3,0}, '{'h8c,1,7,7,0}, '{'h8f,1,'he,'he,0},
         '{'h89,1,'hf,0,0}, '{'h83,1,6,0,1}, '{'h82,1,'hf,5,0}};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr)
            wr(rows[i].idx, rows[i].wd);
         apb(rows[i].idx, 1'b0, 4'h0);
         chk_data(rdat, {28'h0, rows[i].exp});
         chk_flag(rerr, rows[i].err);
      end
      $display("Register table test done");
      // Reset in mid-run clears everything
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk('h80, 0);
      rd_chk('h82, 0);
      rd_chk('h84, 0);
      wr('h84, 5);
      wr('h82, 2);
      rd_chk('h88, 5);
      wr('h82, 1);
      rd_chk('h82, 1);
      poll('h88, 4);
      wr('h82, 0);
      wr('h82, 2);
      repeat (300) @(posedge pclk);
      rd_chk('h88, 5);
      $display("Reload and run test done");
      wr('h84, 1);
      wr('h82, 3);
      stays(1'b0);
      wr('h81, 1);
      wait_out(1'b1);
      wait_out(1'b0);
      wr('h81, 3);
      stays(1'b0);
      // Compare of 0 meets underflow in the same step, so PWM would stay low
      wr('h8c, 1);
      wr('h81, 5);
      wait_out(1'b1);
      wait_out(1'b0);
      $display("Output test done");
      wr('h82, 0);
      wr('h81, 0);
      wr('h84, 0);
      wr('h85, 1);
      wr('h80, 5);
      wr('h82, 3);
      i_event_source.send(3, 4);
      rd_chk('h88, 'hd);
      wr('h80, 4);
      i_event_source.send(2, 4);
      rd_chk('h88, 'hb);
      wr('h80, 6);
      // Short pulses must vanish in the filter, long ones survive
      i_event_source.send(3, 5);
      rd_chk('h88, 'hb);
      i_event_source.send(2, 40);
      rd_chk('h88, 9);
      $display("Event test done");
      wr('h82, 0);
      wr('h80, 8);
      wr('h84, 0);
      wr('h85, 0);
      wr('h86, 3);
      wr('h82, 'hf);
      rd_chk('h8a, 3);
      poll('h8a, 2);
      rd_chk('h82, 5);
      $display("Chained test done");
      conclude();
   end
endmodule
`default_nettype wire
